// ==== design/flash_erase_write_sequencer.sv ====
// Flash controller: page erase, word programming, DMA pacing, timeout.
// Notes on behaviour
// - Page erase leaves every bit of the page at one (array erases).
// - Setting the erase bit starts erase of page high address bits 6:1.
// - Erase and write set together: erase first, then the word write.
// - Busy flag bit 7 reads one while any write or erase is active.
// - Fetch from flash is stalled until the operation completes.
// - Write and erase timing derive from the six-bit timing field.
// - Timing field resets to 0x2A, the value for a 32 MHz clock.
// - DMA trigger pulses whenever a word is stored in flash.
// - A word feed stalled beyond 40 us clears write and drops the word.
// - Pending flag bit 6 is high during each word programming.
// - Bit 4 keeps flash read enables on; zero drives them on demand.
// - Write bit 1 and erase bit 0 start operations and read as zero.
// - Data port bytes go to flash programming once write is set.
// - High address bits 6:0 hold the upper word address; bit 7 unused.
// - Four bytes, least significant first, form a word, then program.
// - Writes address flash by word with a 15-bit address.
`timescale 1ns/1ps
module flash_erase_write_sequencer
   import flash_seq_pkg::*;
#(
   parameter int ERASE_CYCLE_TICKS = flash_seq_pkg::ERASE_TICKS
)
(
   input  wire logic                           clock,
   input  wire logic                           srst,
   input  wire logic [7:0]                     sfr_addr,
   input  wire logic                           sfr_wr,
   input  wire logic                           sfr_rd,
   input  wire logic [7:0]                     sfr_wdata,
   output logic      [7:0]                     sfr_rdata,
   input  wire logic                           fetch_from_flash,
   output logic                                fetch_stall,
   input  wire logic                           cpu_read_req,
   output logic                                flash_read_en,
   output logic                                flash_erase_en,
   output logic      [flash_seq_pkg::PAGE_W-1:0] flash_page,
   output logic                                flash_prog_en,
   output logic      [flash_seq_pkg::ADDR_W-1:0] flash_addr,
   output logic      [31:0]                    flash_wdata,
   output logic                                dma_trigger
);
   import flash_seq_pkg::*;

   seq_state_e            state_reg;
   seq_state_e            state_next;
   logic [7:0]            timing_reg;
   logic [7:0]            addr_low_reg;
   logic [7:0]            addr_high_reg;
   logic [7:0]            spare_reg;
   logic [7:0]            data_reg;
   logic                  then_write_reg;
   logic [1:0]            byte_cnt_reg;
   logic [23:0]           low_bytes_reg;
   logic                  busy;
   logic                  pending;
   logic                  wr_cmd;
   logic                  wr_data;
   logic                  cmd_erase;
   logic                  cmd_write;
   logic                  gen_start;
   logic [TICK_W-1:0]     gen_ticks;
   logic                  gen_done;
   logic                  word_full;
   logic [ADDR_W-1:0]     word_addr;

   // Bus decode; only the five mapped addresses respond.
   assign wr_cmd    = sfr_wr && (sfr_addr == ADDR_CMD_STATUS);
   assign wr_data   = sfr_wr && (sfr_addr == ADDR_DATA_PORT);
   assign cmd_erase = wr_cmd && !busy && sfr_wdata[BIT_ERASE];
   assign cmd_write = wr_cmd && !busy && sfr_wdata[BIT_WRITE];

   // Status seen by software and the stall seen by the fetch unit.
   assign busy        = (state_reg != ST_IDLE);
   assign pending     = (state_reg == ST_PROGRAM);
   assign fetch_stall = busy && fetch_from_flash;

   // The fourth byte of a word arrives while bytes are being taken.
   assign word_full = (state_reg == ST_FEED) && wr_data
                      && (byte_cnt_reg == 2'd3);
   assign word_addr = {addr_high_reg[6:0], addr_low_reg};

   // Sequencer: erase first when both commands come together, then
   // alternate between taking bytes and programming words.
   always_comb
   begin
      state_next = state_reg;
      gen_start  = 1'b0;
      gen_ticks  = TICK_W'(TIMEOUT_TICKS);
      case (state_reg)
         ST_IDLE:
         begin
            if (cmd_erase)
            begin
               state_next = ST_ERASE;
               gen_start  = 1'b1;
               gen_ticks  = TICK_W'(ERASE_CYCLE_TICKS);
            end
            else if (cmd_write)
            begin
               state_next = ST_FEED;
               gen_start  = 1'b1;
            end
         end
         ST_ERASE:
         begin
            if (gen_done)
            begin
               state_next = then_write_reg ? ST_FEED : ST_IDLE;
               gen_start  = then_write_reg;
            end
         end
         ST_FEED:
         begin
            if (word_full)
            begin
               state_next = ST_PROGRAM;
               gen_start  = 1'b1;
               gen_ticks  = TICK_W'(WRITE_TICKS);
            end
            else if (gen_done)
            begin
               state_next = ST_IDLE;
            end
         end
         ST_PROGRAM:
         begin
            if (gen_done)
            begin
               state_next = ST_FEED;
               gen_start  = 1'b1;
            end
         end
         default:
         begin
            state_next = ST_IDLE;
         end
      endcase
   end

   // State register.
   always_ff @(posedge clock)
   begin
      if (srst)
         state_reg <= ST_IDLE;
      else
         state_reg <= state_next;
   end

   // Remembers that a write follows the erase started with it.
   always_ff @(posedge clock)
   begin
      if (srst)
         then_write_reg <= 1'b0;
      else if (cmd_erase)
         then_write_reg <= sfr_wdata[BIT_WRITE];
   end

   // Command bits are never stored, so they always read as zero; only
   // the spare and continuous read bits are kept.
   always_ff @(posedge clock)
   begin
      if (srst)
         spare_reg <= RST_CMD_SPARE;
      else if (wr_cmd)
         spare_reg <= {2'b00, sfr_wdata[5:2], 2'b00};
   end

   // Timing register feeding the tick generator.
   always_ff @(posedge clock)
   begin
      if (srst)
         timing_reg <= RST_TIMING;
      else if (sfr_wr && (sfr_addr == ADDR_TIMING))
         timing_reg <= sfr_wdata;
   end

   // Word address; it steps to the next word after each programmed
   // word so a DMA block lands in consecutive words. The hardware step
   // wins over a software write in the same cycle.
   always_ff @(posedge clock)
   begin
      if (srst)
      begin
         addr_low_reg  <= RST_WORD_LOW;
         addr_high_reg <= RST_WORD_HIGH;
      end
      else if (state_reg == ST_PROGRAM && gen_done)
      begin
         {addr_high_reg[6:0], addr_low_reg} <= word_addr
                                               + ADDR_W'(1);
      end
      else if (sfr_wr && (sfr_addr == ADDR_WORD_LOW))
      begin
         addr_low_reg <= sfr_wdata;
      end
      else if (sfr_wr && (sfr_addr == ADDR_WORD_HIGH))
      begin
         addr_high_reg <= sfr_wdata;
      end
   end

   // Data port holds the last byte written, whatever the state.
   always_ff @(posedge clock)
   begin
      if (srst)
         data_reg <= RST_DATA_PORT;
      else if (wr_data)
         data_reg <= sfr_wdata;
   end

   // Byte assembly, first byte least significant. The count restarts
   // on every entry to byte taking, so a timed-out word is dropped.
   always_ff @(posedge clock)
   begin
      if (srst || state_reg != ST_FEED)
         byte_cnt_reg <= 2'd0;
      else if (wr_data)
         byte_cnt_reg <= byte_cnt_reg + 2'd1;
   end

   // Low three bytes wait here until the word is complete.
   always_ff @(posedge clock)
   begin
      if (srst)
         low_bytes_reg <= '0;
      else if (state_reg == ST_FEED && wr_data)
         low_bytes_reg <= {sfr_wdata, low_bytes_reg[23:8]};
   end

   // Word and address to the array are held for the whole programming.
   always_ff @(posedge clock)
   begin
      if (srst)
      begin
         flash_wdata <= '0;
         flash_addr  <= '0;
      end
      else if (word_full)
      begin
         flash_wdata <= {sfr_wdata, low_bytes_reg};
         flash_addr  <= word_addr;
      end
   end

   // Array strobes. Erase drives the array to all ones in the page.
   always_ff @(posedge clock)
   begin
      if (srst)
      begin
         flash_erase_en <= 1'b0;
         flash_prog_en  <= 1'b0;
         flash_page     <= '0;
      end
      else
      begin
         flash_erase_en <= (state_next == ST_ERASE);
         flash_prog_en  <= (state_next == ST_PROGRAM);
         if (cmd_erase)
            flash_page <= addr_high_reg[PAGE_MSB:PAGE_LSB];
      end
   end

   // Read enables: always on in continuous mode, otherwise only for
   // requests while no operation holds the array. Continuous mode
   // trades power for fewer enable toggles.
   always_ff @(posedge clock)
   begin
      if (srst)
         flash_read_en <= 1'b0;
      else
         flash_read_en <= spare_reg[BIT_CONT_READ]
                          || (cpu_read_req && !busy);
   end

   // DMA trigger: once when the write starts and once per stored word.
   always_ff @(posedge clock)
   begin
      if (srst)
         dma_trigger <= 1'b0;
      else
         dma_trigger <= (state_reg != ST_FEED)
                        && (state_next == ST_FEED);
   end

   // Registered read data, one cycle after the read strobe.
   always_ff @(posedge clock)
   begin
      if (srst)
         sfr_rdata <= 8'h00;
      else if (sfr_rd)
      begin
         case (sfr_addr)
            ADDR_TIMING:     sfr_rdata <= timing_reg;
            ADDR_WORD_LOW:   sfr_rdata <= addr_low_reg;
            ADDR_WORD_HIGH:  sfr_rdata <= addr_high_reg;
            ADDR_CMD_STATUS: sfr_rdata <= {busy, pending,
                                           spare_reg[5:0]};
            ADDR_DATA_PORT:  sfr_rdata <= data_reg;
            default:         sfr_rdata <= 8'h00;
         endcase
      end
   end

   // One generator times erase, programming and the feed timeout.
   flash_timing_gen
   #(
      .TICK_W   (TICK_W),
      .TIMING_W (TIMING_W)
   )
   u_timing
   (
      .clock  (clock),
      .srst   (srst),
      .timing (timing_reg[TIMING_W-1:0]),
      .start  (gen_start),
      .ticks  (gen_ticks),
      .done   (gen_done)
   );

endmodule

// ==== design/flash_seq_pkg.sv ====
// Package with register map, field layout and timing constants.
package flash_seq_pkg;

   // Register addresses on the special function register bus.
   localparam logic [7:0] ADDR_TIMING       = 8'hAB;
   localparam logic [7:0] ADDR_WORD_LOW     = 8'hAC;
   localparam logic [7:0] ADDR_WORD_HIGH    = 8'hAD;
   localparam logic [7:0] ADDR_CMD_STATUS   = 8'hAE;
   localparam logic [7:0] ADDR_DATA_PORT    = 8'hAF;

   // Field positions in the command and status register, and the page field of the high address register.
   localparam int BIT_ERASE      = 0;
   localparam int BIT_WRITE      = 1;
   localparam int BIT_CONT_READ  = 4;
   localparam int BIT_PENDING    = 6;
   localparam int BIT_BUSY       = 7;
   localparam int PAGE_LSB       = 1;
   localparam int PAGE_MSB       = 6;

   // Reset values.
   localparam logic [7:0] RST_TIMING     = 8'h2A;
   localparam logic [7:0] RST_WORD_LOW   = 8'h00;
   localparam logic [7:0] RST_WORD_HIGH  = 8'h00;
   localparam logic [7:0] RST_CMD_SPARE  = 8'h00;
   localparam logic [7:0] RST_DATA_PORT  = 8'h00;

   // Widths.
   localparam int TIMING_W = 6;
   localparam int ADDR_W   = 15;
   localparam int PAGE_W   = 6;
   localparam int TICK_W   = 16;

   // Operation times, in nanoseconds, as the array needs them.
   localparam int WRITE_TIME_NS   = 20000;
   localparam int ERASE_TIME_NS   = 20000000;
   localparam int TIMEOUT_TIME_NS = 40000;

   // The timing value counts clock cycles per tick; at its nominal
   // setting (42 at 32 MHz) one tick lasts 42000/32 ns.
   localparam int NOMINAL_TIMING  = 42;
   localparam int NOMINAL_CLK_MHZ = 32;
   localparam int TICK_NS = NOMINAL_TIMING * 1000 / NOMINAL_CLK_MHZ;

   // Minimum times round up, the timeout (a longest time) rounds down.
   localparam int WRITE_TICKS   = (WRITE_TIME_NS + TICK_NS - 1) / TICK_NS;
   localparam int ERASE_TICKS   = (ERASE_TIME_NS + TICK_NS - 1) / TICK_NS;
   localparam int TIMEOUT_TICKS = TIMEOUT_TIME_NS / TICK_NS;

   // Sequencer states.
   typedef enum logic [1:0] {
      ST_IDLE,
      ST_ERASE,
      ST_FEED,
      ST_PROGRAM
   } seq_state_e;

endpackage

// ==== design/flash_timing_gen.sv ====
// Tick generator and interval counter paced by the program timing value.
`timescale 1ns/1ps
module flash_timing_gen
#(
   parameter int TICK_W   = 16,
   parameter int TIMING_W = 6
)
(
   input  wire logic                clock,
   input  wire logic                srst,
   input  wire logic [TIMING_W-1:0] timing,
   input  wire logic                start,
   input  wire logic [TICK_W-1:0]   ticks,
   output logic                     done
);

   logic [TIMING_W-1:0] presc_reg;
   logic [TICK_W-1:0]   left_reg;
   logic                run_reg;
   logic                tick;

   // A timing value of zero behaves as one so the interval still ends.
   assign tick = (presc_reg + TIMING_W'(1) >= timing);

   // Prescaler restarts with every interval so each one is full length.
   always_ff @(posedge clock)
   begin
      if (srst || start || tick)
         presc_reg <= '0;
      else
         presc_reg <= presc_reg + TIMING_W'(1);
   end

   // Interval counter; a new start overrides one still running.
   always_ff @(posedge clock)
   begin
      if (srst)
      begin
         left_reg <= '0;
         run_reg  <= 1'b0;
         done     <= 1'b0;
      end
      else if (start)
      begin
         left_reg <= ticks;
         run_reg  <= 1'b1;
         done     <= 1'b0;
      end
      else if (run_reg && tick)
      begin
         left_reg <= left_reg - TICK_W'(1);
         run_reg  <= (left_reg > TICK_W'(1));
         done     <= (left_reg <= TICK_W'(1));
      end
      else
      begin
         done <= 1'b0;
      end
   end

endmodule

// ==== testbench/flash_seq_properties.sv ====
// Port checker for the flash erase and write sequencer.
`timescale 1ns/1ps
module flash_seq_properties
#(
   parameter int ERASE_CYCLE_TICKS = 4
)
(
   input wire logic                              clock,
   input wire logic                              srst,
   input wire logic [7:0]                        sfr_addr,
   input wire logic                              sfr_wr,
   input wire logic                              sfr_rd,
   input wire logic [7:0]                        sfr_wdata,
   input wire logic [7:0]                        sfr_rdata,
   input wire logic                              fetch_from_flash,
   input wire logic                              fetch_stall,
   input wire logic                              cpu_read_req,
   input wire logic                              flash_read_en,
   input wire logic                              flash_erase_en,
   input wire logic [flash_seq_pkg::PAGE_W-1:0] flash_page,
   input wire logic                              flash_prog_en,
   input wire logic [flash_seq_pkg::ADDR_W-1:0] flash_addr,
   input wire logic [31:0]                       flash_wdata,
   input wire logic                              dma_trigger
);
   import flash_seq_pkg::*;
   logic [7:0]  high_reg;
   logic [5:0]  tim_reg;
   logic [31:0] ecnt_reg;
   logic [31:0] erase_exp;
   logic        erase_cmd;
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (srst);
   // Shadows of page and timing registers, as the bus wrote them.
   always_ff @(posedge clock)
   begin
      if (srst)
      begin
         high_reg <= RST_WORD_HIGH;
         tim_reg  <= RST_TIMING[5:0];
      end
      else if (sfr_wr && sfr_addr == ADDR_WORD_HIGH)
         high_reg <= sfr_wdata;
      else if (sfr_wr && sfr_addr == ADDR_TIMING)
         tim_reg <= sfr_wdata[5:0];
   end
   // Erase length in cycles; a zero timing value paces like one.
   always_ff @(posedge clock)
   begin
      if (srst || !flash_erase_en)
         ecnt_reg <= 32'h0;
      else
         ecnt_reg <= ecnt_reg + 32'h1;
   end
   assign erase_exp = ERASE_CYCLE_TICKS *
                      ((tim_reg == 6'h00) ? 32'h1 : {26'h0, tim_reg});
   assign erase_cmd = sfr_wr && sfr_addr == ADDR_CMD_STATUS &&
                      sfr_wdata[BIT_ERASE];
   erase_cause_a: assert property
      ($rose(flash_erase_en) |-> $past(erase_cmd))
      else $error("erase began without an erase command");
   page_select_a: assert property
      ($rose(flash_erase_en) |-> flash_page == high_reg[PAGE_MSB:PAGE_LSB])
      else $error("erased page differs from high address bits");
   erase_length_a: assert property
      ($fell(flash_erase_en) |-> ecnt_reg >= erase_exp &&
       ecnt_reg <= erase_exp + 32'h8)
      else $error("erase length does not follow the timing value");
   fetch_stall_a: assert property
      ((flash_erase_en || flash_prog_en) && fetch_from_flash |-> fetch_stall)
      else $error("fetch not stalled during an operation");
   erase_first_a: assert property
      (!(flash_erase_en && flash_prog_en))
      else $error("programming overlaps erase");
   word_hold_a: assert property
      (flash_prog_en && $past(flash_prog_en) |->
       $stable(flash_addr) && $stable(flash_wdata))
      else $error("word or address moved during programming");
   dma_pulse_a: assert property
      (dma_trigger |=> !dma_trigger)
      else $error("dma trigger longer than one cycle");
   dma_ready_a: assert property
      ($fell(flash_prog_en) |-> ##[0:4] dma_trigger)
      else $error("no dma trigger after a stored word");
   cmd_zero_a: assert property
      (sfr_rd && sfr_addr == ADDR_CMD_STATUS |=> sfr_rdata[1:0] == 2'b00)
      else $error("command bits read back nonzero");
   busy_read_a: assert property
      (sfr_rd && sfr_addr == ADDR_CMD_STATUS &&
       (flash_erase_en || flash_prog_en) |=> sfr_rdata[BIT_BUSY])
      else $error("busy flag low during an operation");
   cover property ($fell(flash_erase_en));
   cover property ($fell(flash_prog_en));
   cover property (flash_erase_en ##[1:60] flash_prog_en);
endmodule
bind flash_erase_write_sequencer flash_seq_properties
   #(.ERASE_CYCLE_TICKS(ERASE_CYCLE_TICKS)) u_flash_seq_properties
   (.clock(clock), .srst(srst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
    .fetch_from_flash(fetch_from_flash), .fetch_stall(fetch_stall),
    .cpu_read_req(cpu_read_req), .flash_read_en(flash_read_en),
    .flash_erase_en(flash_erase_en), .flash_page(flash_page),
    .flash_prog_en(flash_prog_en), .flash_addr(flash_addr),
    .flash_wdata(flash_wdata), .dma_trigger(dma_trigger));

// ==== testbench/flash_array_model.sv ====
// Behavioural flash array window and DMA trigger counter.
`timescale 1ns/1ps
module flash_array_model
(
   input wire logic                              clock,
   input wire logic                              flash_erase_en,
   input wire logic                              flash_prog_en,
   input wire logic [flash_seq_pkg::ADDR_W-1:0] flash_addr,
   input wire logic [31:0]                       flash_wdata,
   input wire logic                              dma_trigger
);
   import flash_seq_pkg::*;
   logic [31:0] mem [16];
   logic        prog_q;
   int          dma_count;
   int          prog_count;
   // Cells start at zero so that only a real erase can show ones.
   initial
   begin
      foreach (mem[i])
         mem[i] = 32'h0;
      prog_q = 1'b0;
      dma_count = 0;
      prog_count = 0;
   end
   // The window holds 16 words, fewer than a page, so any erase clears it whole.
   // Programming can only clear bits, as in a real array.
   always @(posedge clock)
   begin
      if (flash_erase_en)
         foreach (mem[i])
            mem[i] <= 32'hFFFF_FFFF;
      if (flash_prog_en)
         mem[flash_addr[3:0]] <= mem[flash_addr[3:0]] & flash_wdata;
      if (flash_prog_en && !prog_q)
         prog_count <= prog_count + 1;
      if (dma_trigger)
         dma_count <= dma_count + 1;
      prog_q <= flash_prog_en;
   end
endmodule

// ==== testbench/tb.sv ====
// Self-checking bench for the flash erase and write sequencer.
`timescale 1ns/1ps
module tb;
   import flash_seq_pkg::*;
   logic              clock;
   logic              srst;
   logic [7:0]        sfr_addr;
   logic              sfr_wr;
   logic              sfr_rd;
   logic [7:0]        sfr_wdata;
   logic [7:0]        sfr_rdata;
   logic              fetch_from_flash;
   logic              fetch_stall;
   logic              cpu_read_req;
   logic              flash_read_en;
   logic              flash_erase_en;
   logic [PAGE_W-1:0] flash_page;
   logic              flash_prog_en;
   logic [ADDR_W-1:0] flash_addr;
   logic [31:0]       flash_wdata;
   logic              dma_trigger;
   logic [7:0]        rd_val;
   int                bad_count;
   int                num_checks;
   flash_erase_write_sequencer #(.ERASE_CYCLE_TICKS(4))
      u_flash_erase_write_sequencer
   (.clock(clock), .srst(srst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
    .fetch_from_flash(fetch_from_flash), .fetch_stall(fetch_stall),
    .cpu_read_req(cpu_read_req), .flash_read_en(flash_read_en),
    .flash_erase_en(flash_erase_en), .flash_page(flash_page),
    .flash_prog_en(flash_prog_en), .flash_addr(flash_addr),
    .flash_wdata(flash_wdata), .dma_trigger(dma_trigger));
   flash_array_model u_flash_array_model
   (.clock(clock), .flash_erase_en(flash_erase_en),
    .flash_prog_en(flash_prog_en), .flash_addr(flash_addr),
    .flash_wdata(flash_wdata), .dma_trigger(dma_trigger));
   task automatic conclude;
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] exp,
                      input logic [31:0] got);
      num_checks++;
      if (got !== exp)
      begin
         bad_count++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic fail(input string what);
      bad_count++;
      $display("ERROR %s expected done seen timeout", what);
      conclude();
   endtask
   // Bus tasks enter and leave just after an edge, with an idle cycle.
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      sfr_addr = a;
      sfr_wdata = d;
      sfr_wr = 1'b1;
      @(posedge clock);
      #1;
      sfr_wr = 1'b0;
      @(posedge clock);
      #1;
   endtask
   task automatic rd(input logic [7:0] a);
      sfr_addr = a;
      sfr_rd = 1'b1;
      @(posedge clock);
      #1;
      sfr_rd = 1'b0;
      rd_val = sfr_rdata;
      @(posedge clock);
      #1;
   endtask
   task automatic feed(input logic [31:0] w);
      for (int i = 0; i < 4; i++)
         wr(ADDR_DATA_PORT, w[8*i +: 8]);
   endtask
   task automatic wait_idle;
      rd_val = 8'hFF;
      for (int i = 0; i < 200 && rd_val[BIT_BUSY] !== 1'b0; i++)
         rd(ADDR_CMD_STATUS);
      if (rd_val[BIT_BUSY] !== 1'b0)
         fail("busy flag");
   endtask
   task automatic wait_dma(input int n);
      for (int i = 0; i < 300 && u_flash_array_model.dma_count < n; i++)
      begin
         @(posedge clock);
         #1;
      end
      if (u_flash_array_model.dma_count < n)
         fail("dma trigger");
   endtask
   // Reset values, the unused high address bit and an unmapped address.
   task automatic t_reset;
      rd(ADDR_TIMING);
      chk("timing", 32'h2A, 32'(rd_val));
      rd(ADDR_CMD_STATUS);
      chk("status", 32'h0, 32'(rd_val));
      wr(ADDR_WORD_HIGH, 8'h80);
      rd(ADDR_WORD_HIGH);
      chk("addr high", 32'h80, 32'(rd_val));
      rd(8'hAA);
      chk("unmapped", 32'h0, 32'(rd_val));
   endtask
   // Erase from flash, with a write command sent while busy.
   task automatic t_erase;
      wr(ADDR_TIMING, 8'h02);
      wr(ADDR_WORD_HIGH, 8'h06);
      fetch_from_flash = 1'b1;
      wr(ADDR_CMD_STATUS, 8'h01);
      chk("erase en", 32'h1, 32'(flash_erase_en));
      chk("page", 32'h3, 32'(flash_page));
      chk("stall", 32'h1, 32'(fetch_stall));
      wr(ADDR_CMD_STATUS, 8'h02);
      rd(ADDR_CMD_STATUS);
      chk("busy", 32'h80, 32'(rd_val & 8'hC3));
      wait_idle();
      chk("stall end", 32'h0, 32'(fetch_stall));
      chk("erased", 32'hFFFFFFFF, u_flash_array_model.mem[3]);
      chk("no write", 32'h0, 32'(u_flash_array_model.dma_count));
      fetch_from_flash = 1'b0;
   endtask
   // Two DMA-paced words, then a partial word left to time out.
   task automatic t_write;
      wr(ADDR_WORD_LOW, 8'h05);
      wr(ADDR_WORD_HIGH, 8'h00);
      wr(ADDR_CMD_STATUS, 8'h02);
      wait_dma(1);
      feed(32'h44332211);
      chk("prog en", 32'h1, 32'(flash_prog_en));
      chk("word", 32'h44332211, flash_wdata);
      chk("addr", 32'h5, 32'(flash_addr));
      rd(ADDR_CMD_STATUS);
      chk("pending", 32'hC0, 32'(rd_val & 8'hC0));
      wait_dma(2);
      feed(32'h88776655);
      chk("addr next", 32'h6, 32'(flash_addr));
      wait_dma(3);
      chk("stored", 32'h88776655, u_flash_array_model.mem[6]);
      wr(ADDR_DATA_PORT, 8'h99);
      wr(ADDR_DATA_PORT, 8'h98);
      rd(ADDR_DATA_PORT);
      chk("data port", 32'h98, 32'(rd_val));
      wait_idle();
      chk("dropped", 32'h2, 32'(u_flash_array_model.prog_count));
   endtask
   // Erase and write together: the erase runs to its end first.
   task automatic t_both;
      wr(ADDR_WORD_LOW, 8'h08);
      wr(ADDR_CMD_STATUS, 8'h03);
      chk("erase first", 32'h2, 32'({flash_erase_en, flash_prog_en}));
      chk("no feed", 32'h3, 32'(u_flash_array_model.dma_count));
      wait_dma(4);
      chk("wiped", 32'hFFFFFFFF, u_flash_array_model.mem[5]);
      feed(32'hA5A50F0F);
      wait_dma(5);
      chk("stored", 32'hA5A50F0F, u_flash_array_model.mem[8]);
      wait_idle();
   endtask
   // Read enables: continuous mode, off when idle, on demand.
   task automatic t_read;
      wr(ADDR_CMD_STATUS, 8'h3C);
      chk("cont read", 32'h1, 32'(flash_read_en));
      rd(ADDR_CMD_STATUS);
      chk("spare bits", 32'h3C, 32'(rd_val));
      wr(ADDR_CMD_STATUS, 8'h00);
      chk("read idle", 32'h0, 32'(flash_read_en));
      cpu_read_req = 1'b1;
      repeat (2) @(posedge clock);
      #1;
      chk("read demand", 32'h1, 32'(flash_read_en));
      cpu_read_req = 1'b0;
   endtask
   // Free-running clock at 100 MHz.
   initial
   begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   // Reset for two cycles, then the scenarios in order.
   initial
   begin
      srst = 1'b1;
      sfr_addr = 8'h00;
      sfr_wr = 1'b0;
      sfr_rd = 1'b0;
      sfr_wdata = 8'h00;
      fetch_from_flash = 1'b0;
      cpu_read_req = 1'b0;
      bad_count = 0;
      num_checks = 0;
      repeat (2) @(posedge clock);
      #1;
      srst = 1'b0;
      t_reset();
      t_erase();
      t_write();
      t_both();
      t_read();
      conclude();
   end
endmodule
